// >>> bcd_pkg.sv
package bcd_pkg;
	// ----------------------------------------------------------------
	// Instruction word layout
	// ----------------------------------------------------------------
	localparam int INSTR_W = 14;
	localparam int ADDR_W = 7;
	localparam int BIT_W = 3;
	localparam int DATA_W = 8;
	localparam int PC_W = 13;
	localparam int CALL_K_W = 11;
	localparam int ADDR_LSB = 0;
	localparam int BIT_LSB = 7;
	localparam int BIT_OP_LSB = 10;
	localparam int BIT_OP_W = 4;
	localparam int CALL_OP_LSB = 11;
	localparam int CALL_OP_W = 3;
	localparam int CLR_OP_LSB = 7;
	localparam int CLR_OP_W = 7;
	localparam int LATCH_PAGE_LSB = 3;
	localparam int PAGE_W = 2;

	// ----------------------------------------------------------------
	// Opcode patterns
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_BIT_CLEAR = 4'h4;
	localparam logic [3:0] OP_BIT_SET = 4'h5;
	localparam logic [3:0] OP_SKIP_ZERO = 4'h6;
	localparam logic [3:0] OP_SKIP_ONE = 4'h7;
	localparam logic [2:0] OP_CALL = 3'h4;
	localparam logic [6:0] OP_CLEAR_REG = 7'h03;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	typedef enum logic [2:0] {
		BCD_OP_NONE,
		BCD_OP_CLEAR_BIT,
		BCD_OP_SET_BIT,
		BCD_OP_SKIP_ZERO,
		BCD_OP_SKIP_ONE,
		BCD_OP_CALL,
		BCD_OP_CLEAR_REG
	} bcd_op_type;
endpackage

// >>> bcd_dec_if.sv
`timescale 1ns/1ps
interface bcd_dec_if;
	logic [13:0] instr;
	bcd_pkg::bcd_op_type op;
	logic [6:0] reg_addr;
	logic [2:0] bit_index;
	logic [10:0] call_target;

	modport decoder (input instr, output op, reg_addr, bit_index, call_target);
	modport core (output instr, input op, reg_addr, bit_index, call_target);
endinterface

// >>> bcd_field_decode.sv
`timescale 1ns/1ps
module bcd_field_decode (
	// Decode channel
	bcd_dec_if.decoder dec
);
	wire [3:0] bit_op;
	wire [2:0] call_op;
	wire [6:0] clr_op;

	assign bit_op = dec.instr[bcd_pkg::BIT_OP_LSB +: bcd_pkg::BIT_OP_W];
	assign call_op = dec.instr[bcd_pkg::CALL_OP_LSB +: bcd_pkg::CALL_OP_W];
	assign clr_op = dec.instr[bcd_pkg::CLR_OP_LSB +: bcd_pkg::CLR_OP_W];
	// Register address and bit index sit in the same place for every bit form. (see RULE6)
	assign dec.reg_addr = dec.instr[bcd_pkg::ADDR_LSB +: bcd_pkg::ADDR_W];
	assign dec.bit_index = dec.instr[bcd_pkg::BIT_LSB +: bcd_pkg::BIT_W];
	assign dec.call_target = dec.instr[bcd_pkg::CALL_K_W-1:0];

	// Pattern 01 11 selects the test-skip-if-one form. (see RULE10)
	assign dec.op = (bit_op == bcd_pkg::OP_BIT_CLEAR) ? bcd_pkg::BCD_OP_CLEAR_BIT :
		(bit_op == bcd_pkg::OP_BIT_SET) ? bcd_pkg::BCD_OP_SET_BIT :
		(bit_op == bcd_pkg::OP_SKIP_ZERO) ? bcd_pkg::BCD_OP_SKIP_ZERO :
		(bit_op == bcd_pkg::OP_SKIP_ONE) ? bcd_pkg::BCD_OP_SKIP_ONE :
		(call_op == bcd_pkg::OP_CALL) ? bcd_pkg::BCD_OP_CALL :
		(clr_op == bcd_pkg::OP_CLEAR_REG) ? bcd_pkg::BCD_OP_CLEAR_REG :
		bcd_pkg::BCD_OP_NONE;
endmodule

// >>> bcd_core.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: Bit clear zeroes chosen bit of addressed register in one cycle, flags untouched.
// RULE2: Bit set forces chosen bit to one in one cycle, flags untouched.
// RULE3: Skip-if-zero suppresses next instruction when the tested bit reads zero.
// RULE4: Skip-if-one suppresses next instruction when the tested bit reads one.
// RULE5: A taken skip discards the fetched word and runs a no-operation instead.
// RULE6: Register address is low seven bits, bit index the three above.
// RULE7: Call pushes the next address onto the stack top, two cycles, no flags.
// RULE8: Call loads eleven-bit target into low PC, latch bits 4:3 into PC 12:11.
// RULE9: Clear-register writes zero to the register and sets the zero flag.
// RULE10: Pattern 01 11 in upper opcode bits selects test-skip-if-one.
// RULE11: Bit set and clear rewrite the whole register from the value read.
module bcd_core (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Instruction fetch
	input wire logic [13:0] fetch_word,
	output logic [12:0] pc_out,
	// Register file access
	output logic [6:0] file_addr,
	input wire logic [7:0] file_rdata,
	output logic file_we,
	output logic [7:0] file_wdata,
	input wire logic [7:0] program_counter_upper_latch,
	// Status zero flag
	output logic zero_set,
	// Return stack
	output logic stack_push,
	output logic [12:0] stack_top_entry,
	// Execution state
	output logic exec_nop
);
	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	bcd_dec_if dec ();
	bcd_field_decode u_decode (
		.dec(dec.decoder)
	);

	logic [12:0] pc_reg;
	logic [12:0] pc_next;
	logic flush_reg;
	logic flush_next;
	logic [12:0] stack_reg;

	wire active;
	wire is_clear_bit;
	wire is_set_bit;
	wire is_skip_zero;
	wire is_skip_one;
	wire is_call;
	wire is_clear_reg;
	wire tested_bit;
	wire skip_taken;
	wire [7:0] bit_mask;
	wire [12:0] pc_plus_one;
	wire [12:0] call_dest;
	wire is_bit_write;
	wire is_skip;
	wire [7:0] set_value;
	wire [7:0] clear_value;

	assign dec.instr = fetch_word;
	// A word that follows a taken skip or a call is dropped and runs as a no-operation.
	assign active = ~flush_reg;
	assign is_clear_bit = active && dec.op == bcd_pkg::BCD_OP_CLEAR_BIT;
	assign is_set_bit = active && dec.op == bcd_pkg::BCD_OP_SET_BIT;
	assign is_skip_zero = active && dec.op == bcd_pkg::BCD_OP_SKIP_ZERO;
	assign is_skip_one = active && dec.op == bcd_pkg::BCD_OP_SKIP_ONE;
	assign is_call = active && dec.op == bcd_pkg::BCD_OP_CALL;
	assign is_clear_reg = active && dec.op == bcd_pkg::BCD_OP_CLEAR_REG;
	assign is_bit_write = is_clear_bit || is_set_bit;
	assign is_skip = is_skip_zero || is_skip_one;

	// ----------------------------------------------------------------
	// Register file path
	// ----------------------------------------------------------------
	assign file_addr = dec.reg_addr; // see RULE6
	assign tested_bit = file_rdata[dec.bit_index];
	assign bit_mask = 8'h01 << dec.bit_index;
	assign file_we = is_bit_write || is_clear_reg;
	// Only the chosen bit changes; the other seven are written back as read. (see RULE11)
	// The register file must answer the read in the same cycle for this to hold.
	assign set_value = file_rdata | bit_mask; // see RULE2
	assign clear_value = file_rdata & ~bit_mask; // see RULE1
	assign file_wdata = is_clear_reg ? bcd_pkg::ZERO_BYTE : // see RULE9
		is_set_bit ? set_value :
		clear_value;
	// Bit operations never touch a flag; only clear-register sets zero. (see RULE9)
	assign zero_set = is_clear_reg;

	// ----------------------------------------------------------------
	// Skip and call sequencing
	// ----------------------------------------------------------------
	assign skip_taken = (is_skip_zero && !tested_bit) || // see RULE3
		(is_skip_one && tested_bit); // see RULE4
	assign pc_plus_one = pc_reg + 13'h0001;
	assign call_dest = {program_counter_upper_latch[bcd_pkg::LATCH_PAGE_LSB +: bcd_pkg::PAGE_W],
		dec.call_target}; // see RULE8
	assign pc_next = is_call ? call_dest : pc_plus_one;
	// Flushing the prefetched word gives the second cycle of a taken skip or call. (see RULE5)
	assign flush_next = skip_taken || is_call;
	assign stack_push = is_call; // see RULE7
	assign pc_out = pc_reg;
	assign stack_top_entry = stack_reg;
	assign exec_nop = flush_reg;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pc_reg <= bcd_pkg::PC_RESET;
		end else begin
			pc_reg <= pc_next;
		end
	end

	// A flush lasts one word only, because a discarded word can never raise flush_next.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			flush_reg <= 1'b0;
		end else begin
			flush_reg <= flush_next;
		end
	end

	// Return address is the word after the call. (see RULE7)
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			stack_reg <= bcd_pkg::PC_RESET;
		end else if (is_call) begin
			stack_reg <= pc_plus_one;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_clear_bit_value: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE1
		is_clear_bit |-> file_we && !file_wdata[dec.bit_index] && !zero_set)
		else $error("bit clear did not zero the bit");
	a_set_bit_value: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE2
		is_set_bit |-> file_we && file_wdata[dec.bit_index] && !zero_set)
		else $error("bit set did not set the bit");
	a_skip_zero_flush: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE3
		(is_skip_zero && !tested_bit) |=> exec_nop && !file_we)
		else $error("skip on zero not taken");
	a_skip_one_flush: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE4
		(is_skip_one && tested_bit) |=> exec_nop && !stack_push)
		else $error("skip on one not taken");
	a_no_skip_run: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE5
		((is_skip_zero || is_skip_one) && !skip_taken) |=> !exec_nop)
		else $error("skip taken when bit did not match");
	a_call_push: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE7
		is_call |=> stack_top_entry == $past(pc_out) + 13'h0001 && exec_nop)
		else $error("call pushed wrong return address");
	a_call_target: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE8
		is_call |=> pc_out[10:0] == $past(fetch_word[10:0])
		&& pc_out[12:11] == $past(program_counter_upper_latch[4:3]))
		else $error("call loaded wrong target");
	a_clear_reg_zero: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE9
		is_clear_reg |-> file_we && file_wdata == 8'h00 && zero_set)
		else $error("clear register failed");
	a_rmw_others: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE11
		(is_set_bit || is_clear_bit) |-> ((file_wdata ^ file_rdata) & ~bit_mask) == 8'h00)
		else $error("other bits disturbed");
	a_index_field: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE6
		is_set_bit
		|-> file_wdata == (file_rdata | (8'h01 << fetch_word[9:7])))
		else $error("bit index taken from wrong field");
	a_clear_reg_pattern: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE9
		(!exec_nop && fetch_word[13:7] == 7'h03)
		|-> file_we && zero_set && file_wdata == 8'h00)
		else $error("clear register pattern not executed");

	// ----------------------------------------------------------------
	// Sequencing assertions
	// ----------------------------------------------------------------
	a_discard_quiet: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE5
		exec_nop
		|-> !file_we && !stack_push && !zero_set)
		else $error("discarded word had an effect");
	// The counter steps on discarded words too, so a taken skip costs one address.
	a_pc_step: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE5
		!is_call
		|=> pc_out == $past(pc_out) + 13'h0001)
		else $error("program counter did not step");
	a_skip_no_write: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE3
		is_skip
		|-> !file_we && !zero_set && !stack_push)
		else $error("skip test wrote or pushed");
	// These two watch the raw word, so a decoder slip cannot hide behind the strobes.
	a_zero_pattern: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE3
		(!exec_nop && fetch_word[13:10] == 4'h6 && !file_rdata[fetch_word[9:7]])
		|=> exec_nop)
		else $error("skip on zero pattern not honoured");
	a_one_pattern: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE10
		(!exec_nop && fetch_word[13:10] == 4'h7 && file_rdata[fetch_word[9:7]])
		|=> exec_nop)
		else $error("skip on one pattern not honoured");
	a_call_two_cycles: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE7
		is_call
		|=> exec_nop ##1 !exec_nop)
		else $error("call did not take two cycles");
	a_call_no_write: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE7
		is_call
		|-> !file_we && !zero_set)
		else $error("call wrote a register or flag");
	a_stack_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // see RULE7
		!is_call
		|=> $stable(stack_top_entry))
		else $error("stack top changed without a call");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	c_skip_one: cover property (@(posedge ref_clk) disable iff (!rstn) is_skip_one && tested_bit);
	c_skip_taken: cover property (@(posedge ref_clk) disable iff (!rstn) skip_taken);
	c_call_done: cover property (@(posedge ref_clk) disable iff (!rstn) is_call ##1 exec_nop);
	c_clear_reg: cover property (@(posedge ref_clk) disable iff (!rstn) is_clear_reg);
	c_set_then_clear: cover property (@(posedge ref_clk) disable iff (!rstn)
		is_set_bit ##1 is_clear_bit);
endmodule

// >>> test_bit_call_clear_decoder.sv
`timescale 1ns/1ps
module test_bit_call_clear_decoder;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [13:0] fetch_word = 14'h0000;
	logic [7:0] file_rdata = 8'h00;
	logic [7:0] program_counter_upper_latch = 8'h00;
	logic [12:0] pc_out, stack_top_entry, pc_exp, tos_exp;
	logic [6:0] file_addr;
	logic [7:0] file_wdata;
	logic file_we, zero_set, stack_push, exec_nop, nop_exp;
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;
	wire is_call = fetch_word[13:11] == 3'h4;
	wire taken = fetch_word[13:11] == 3'h3 && file_rdata[fetch_word[9:7]] == fetch_word[10];

	bcd_core i_bcd_core (.ref_clk(ref_clk), .rstn(rstn), .fetch_word(fetch_word),
		.pc_out(pc_out), .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
		.file_wdata(file_wdata), .program_counter_upper_latch(program_counter_upper_latch),
		.zero_set(zero_set), .stack_push(stack_push), .stack_top_entry(stack_top_entry),
		.exec_nop(exec_nop));

	always #12.5 ref_clk = ~ref_clk;

	// ----------------------------------------------------------------
	// Reference sequencing and hang guard
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			end_of_test();
		end
	end

	// A discarded word may itself look like a call or skip, so it must not start one.
	always @(posedge ref_clk) begin
		if (!rstn) begin
			pc_exp <= 13'h0000;
			tos_exp <= 13'h0000;
			nop_exp <= 1'b0;
		end else begin
			nop_exp <= !nop_exp && (is_call || taken);
			pc_exp <= (!nop_exp && is_call) ? {program_counter_upper_latch[4:3], fetch_word[10:0]} : pc_exp + 13'h0001;
			if (!nop_exp && is_call) begin
				tos_exp <= pc_exp + 13'h0001;
			end
		end
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic go(input logic [13:0] w, input logic [7:0] d, input logic we,
			input logic [7:0] wd, input logic z, input logic p);
		@(negedge ref_clk);
		chk("pc_out", {3'h0, pc_exp}, {3'h0, pc_out});
		chk("exec_nop", {15'h0000, nop_exp}, {15'h0000, exec_nop});
		chk("stack_top_entry", {3'h0, tos_exp}, {3'h0, stack_top_entry});
		fetch_word = w;
		file_rdata = d;
		#1;
		chk("file_we", {15'h0000, we}, {15'h0000, file_we});
		chk("zero_set", {15'h0000, z}, {15'h0000, zero_set});
		chk("stack_push", {15'h0000, p}, {15'h0000, stack_push});
		chk("file_addr", {9'h000, w[6:0]}, {9'h000, file_addr});
		if (we) begin
			chk("file_wdata", {8'h00, wd}, {8'h00, file_wdata});
		end
	endtask

	task automatic t_bits();
		for (int b = 0; b < 8; b++) begin
			go({4'h4, b[2:0], 7'h7F}, 8'hA5, 1'b1, 8'hA5 & ~(8'h01 << b), 1'b0, 1'b0);
			go({4'h5, b[2:0], 7'h00}, 8'h5A, 1'b1, 8'h5A | (8'h01 << b), 1'b0, 1'b0);
		end
		$display("bit set and clear done");
	endtask

	task automatic t_skip();
		go({4'h6, 3'h3, 7'h11}, 8'hF7, 1'b0, 8'h00, 1'b0, 1'b0);
		go({4'h5, 3'h0, 7'h12}, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		go({4'h6, 3'h3, 7'h11}, 8'h08, 1'b0, 8'h00, 1'b0, 1'b0);
		go({4'h5, 3'h0, 7'h12}, 8'h00, 1'b1, 8'h01, 1'b0, 1'b0);
		go({4'h7, 3'h7, 7'h20}, 8'h80, 1'b0, 8'h00, 1'b0, 1'b0);
		go({3'h4, 11'h123}, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		go({4'h7, 3'h7, 7'h20}, 8'h7F, 1'b0, 8'h00, 1'b0, 1'b0);
		go({7'h03, 7'h21}, 8'h44, 1'b1, 8'h00, 1'b1, 1'b0);
		$display("skip tests done");
	endtask

	task automatic t_call(input logic [7:0] latch, input logic [10:0] k);
		program_counter_upper_latch = latch;
		go({3'h4, k}, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1);
		go({7'h03, 7'h05}, 8'hFF, 1'b0, 8'h00, 1'b0, 1'b0);
		go({7'h03, 7'h06}, 8'h5A, 1'b1, 8'h00, 1'b1, 1'b0);
		go(14'h0000, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
		$display("call test done");
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(negedge ref_clk);
		rstn = 1'b1;
		t_bits();
		t_skip();
		t_call(8'h18, 11'h7FF);
		t_call(8'hE7, 11'h000);
		t_call(8'h08, 11'h2AA);
		end_of_test();
	end
endmodule
